// ---- rtl/synth_serial_latch_decoder_consts.svh ----
// constants for the serial latch decoder: codes, field positions, reset values, counts
`ifndef SYNTH_SERIAL_LATCH_DECODER_CONSTS_SVH
`define SYNTH_SERIAL_LATCH_DECODER_CONSTS_SVH

// ----------------------------------------------------------------
// word and latch select codes
// ----------------------------------------------------------------
`define SSLD_WORD_W 24
`define SSLD_SEL_FUNCTION 2'h0
`define SSLD_SEL_REFERENCE 2'h1
`define SSLD_SEL_FEEDBACK 2'h2
`define SSLD_SEL_TEST 2'h3

// ----------------------------------------------------------------
// field positions inside a 24-bit word
// ----------------------------------------------------------------
`define SSLD_POS_COUNTER_RESET 4
`define SSLD_POS_FN_CP_GAIN 10
`define SSLD_POS_FB_CP_GAIN 21
`define SSLD_POS_FB_DIV2 22
`define SSLD_POS_FB_DIV2_SEL 23
`define SSLD_POS_LOCK_PRECISION 18
`define SSLD_POS_FACTORY_TEST 19

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SSLD_LATCH_RESET 24'h000000
`define SSLD_GAIN_RESET 1'h0
`define SSLD_LOCK_CYCLES_FINE 3'h5
`define SSLD_LOCK_CYCLES_COARSE 3'h3
`define SSLD_MAIN_COUNT_MIN 13'h0003
`define SSLD_REFDIV_MIN 14'h0001
`define SSLD_CLK_PERIOD_NS 50
`define SSLD_PHASE_WINDOW_NS 15

`endif

// ---- rtl/synth_serial_latch_decoder_pkg.sv ----
// types shared by the serial latch decoder: latch layouts and monitor selections
package synth_serial_latch_decoder_pkg;

	// ----------------------------------------------------------------
	// trailing select pair of every word
	// ----------------------------------------------------------------
	typedef struct packed {
		logic latch_select_upper;
		logic latch_select_lower;
	} latch_select_t;

	// ----------------------------------------------------------------
	// latch layouts, msb first
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0] other_hi;
		logic mute_till_lock;
		logic cp_gain;
		logic [1:0] other_mid;
		logic [2:0] monitor_select;
		logic counter_reset;
		logic [1:0] core_current;
		latch_select_t sel;
	} function_latch_t;

	typedef struct packed {
		logic div2_select;
		logic div2_enable;
		logic cp_gain;
		logic [12:0] main_count;
		logic reserved;
		logic [4:0] swallow_count;
		latch_select_t sel;
	} feedback_latch_t;

	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] band_select_div;
		logic factory_test_enable;
		logic lock_precision_select;
		logic [1:0] antibacklash;
		logic [13:0] refdiv;
		latch_select_t sel;
	} reference_latch_t;

	// ----------------------------------------------------------------
	// monitor pin sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MON_LOW = 3'b000,
		MON_LOCK = 3'b001,
		MON_FEEDBACK = 3'b010,
		MON_HIGH = 3'b011,
		MON_REFERENCE = 3'b100,
		MON_BAND = 3'b101,
		MON_SDATA = 3'b110,
		MON_LOW2 = 3'b111
	} monitor_sel_t;

endpackage

// ---- rtl/synth_serial_latch_decoder.sv ----
// serial front end of an integer-N synthesizer: shift register, three latches, counters
`timescale 1ns/1ns
`include "synth_serial_latch_decoder_consts.svh"

module synth_serial_latch_decoder #(
	parameter int PRESCALER_P = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// serial port, sampled on clock_i
	input wire logic sclk_i,
	input wire logic sdata_i,
	input wire logic load_strobe_i,
	// counter clock ticks, one-cycle pulses
	input wire logic ref_tick_i,
	input wire logic vco_tick_i,
	// latch contents
	output synth_serial_latch_decoder_pkg::function_latch_t function_q_o,
	output synth_serial_latch_decoder_pkg::feedback_latch_t feedback_q_o,
	output synth_serial_latch_decoder_pkg::reference_latch_t reference_q_o,
	// decoded state
	output logic cp_gain_o,
	output logic counters_held_o,
	output logic ref_out_o,
	output logic fb_out_o,
	output logic band_tick_o,
	output logic locked_o,
	output logic monitor_output_pin_o
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	generate
		if (PRESCALER_P < 2 || PRESCALER_P > 32)
		begin : g_bad_p
			$error("prescaler modulus out of range");
		end
	endgenerate

	localparam logic [5:0] P_MOD = 6'(PRESCALER_P);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// count wraps when the next value reaches the limit; limit 0 acts as 1
	function automatic logic term_reached(input logic [18:0] count, input logic [18:0] limit);
		logic [19:0] nxt;
		nxt = {1'h0, count} + 20'h00001;
		return nxt >= {1'h0, limit};
	endfunction

	// total feedback ratio, modulus times main count plus swallow count
	// both factors widened first: a 13-bit product would wrap for large main counts
	function automatic logic [18:0] feedback_ratio(input logic [5:0] p, input logic [12:0] b, input logic [4:0] a);
		return 19'(p) * 19'(b) + {14'h0000, a};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic sclk_prev;
	logic load_prev;
	logic [`SSLD_WORD_W-1:0] shift;
	logic [13:0] rcount;
	logic [18:0] fcount;
	logic vco_half;
	logic [2:0] bcount;
	logic [2:0] lock_run;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire sclk_rise = sclk_i & ~sclk_prev;
	wire load_rise = load_strobe_i & ~load_prev;
	wire [1:0] word_sel = shift[1:0]; // select pair arrives last
	wire load_fn = load_rise && word_sel == `SSLD_SEL_FUNCTION;
	wire load_fb = load_rise && word_sel == `SSLD_SEL_FEEDBACK;
	wire load_ref = load_rise && word_sel == `SSLD_SEL_REFERENCE;
	// test latch words fall through: no test latch, normal operation
	wire held = function_q_o.counter_reset;
	wire [18:0] fb_limit = feedback_ratio(P_MOD, feedback_q_o.main_count, feedback_q_o.swallow_count);
	wire [18:0] ref_limit = {5'h00, reference_q_o.refdiv};
	wire [18:0] band_limit = 19'(4'h1 << reference_q_o.band_select_div);
	// halved input skips every other tick
	wire fb_tick = vco_tick_i & (~feedback_q_o.div2_select | vco_half);
	wire ref_hit = ref_tick_i & ~held & term_reached({5'h00, rcount}, ref_limit);
	wire fb_hit = fb_tick & ~held & term_reached(fcount, fb_limit);
	wire band_hit = ref_out_o & term_reached({16'h0000, bcount}, band_limit);
	wire [2:0] lock_need = reference_q_o.lock_precision_select ? `SSLD_LOCK_CYCLES_FINE : `SSLD_LOCK_CYCLES_COARSE;
	// same-cycle arrival is the finest resolution at 50 ns, coarser than the 15 ns window
	wire good_cycle = ref_out_o & fb_out_o;
	wire bad_cycle = ref_out_o ^ fb_out_o;
	wire [2:0] next_lock_run = bad_cycle ? 3'h0 :
		(good_cycle && lock_run < lock_need) ? lock_run + 3'h1 : lock_run;
	synth_serial_latch_decoder_pkg::monitor_sel_t mon_sel;
	logic monitor_value;

	assign mon_sel = synth_serial_latch_decoder_pkg::monitor_sel_t'(function_q_o.monitor_select);

	// monitor pin source selection
	always_comb
	begin
		case (mon_sel)
			synth_serial_latch_decoder_pkg::MON_LOCK: monitor_value = locked_o;
			synth_serial_latch_decoder_pkg::MON_FEEDBACK: monitor_value = fb_out_o;
			synth_serial_latch_decoder_pkg::MON_HIGH: monitor_value = 1'b1;
			synth_serial_latch_decoder_pkg::MON_REFERENCE: monitor_value = ref_out_o;
			synth_serial_latch_decoder_pkg::MON_BAND: monitor_value = band_tick_o;
			synth_serial_latch_decoder_pkg::MON_SDATA: monitor_value = sdata_i;
			default: monitor_value = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// serial shift register
	// ----------------------------------------------------------------
	// one bit per serial clock rise, msb enters first
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			sclk_prev <= 1'b0;
			load_prev <= 1'b0;
			shift <= `SSLD_LATCH_RESET;
		end
		else
		begin
			sclk_prev <= sclk_i;
			load_prev <= load_strobe_i;
			if (sclk_rise)
				shift <= {shift[`SSLD_WORD_W-2:0], sdata_i};
		end
	end

	// ----------------------------------------------------------------
	// latches, committed only on the strobe rise
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			function_q_o <= `SSLD_LATCH_RESET;
			feedback_q_o <= `SSLD_LATCH_RESET;
			reference_q_o <= `SSLD_LATCH_RESET;
		end
		else
		begin
			if (load_fn)
				function_q_o <= shift;
			if (load_fb)
				feedback_q_o <= shift;
			if (load_ref)
				reference_q_o <= shift;
		end
	end

	// shared gain bit: whichever of the function and feedback latches wrote last sets it
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			cp_gain_o <= `SSLD_GAIN_RESET;
		else if (load_fn)
			cp_gain_o <= shift[`SSLD_POS_FN_CP_GAIN];
		else if (load_fb)
			cp_gain_o <= shift[`SSLD_POS_FB_CP_GAIN];
	end

	// ----------------------------------------------------------------
	// reference and feedback counters
	// ----------------------------------------------------------------
	// counter reset bit forces both counters to their load state
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i || held)
		begin
			rcount <= 14'h0000;
			fcount <= 19'h00000;
			vco_half <= 1'b0;
		end
		else
		begin
			if (ref_tick_i)
				rcount <= ref_hit ? 14'h0000 : rcount + 14'h0001;
			if (fb_tick)
				fcount <= fb_hit ? 19'h00000 : fcount + 19'h00001;
			if (vco_tick_i && feedback_q_o.div2_select)
				vco_half <= ~vco_half;
		end
	end

	// registered counter outputs and held flag
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			ref_out_o <= 1'b0;
			fb_out_o <= 1'b0;
			counters_held_o <= 1'b0;
		end
		else
		begin
			ref_out_o <= ref_hit;
			fb_out_o <= fb_hit;
			counters_held_o <= held;
		end
	end

	// ----------------------------------------------------------------
	// band select clock divider
	// ----------------------------------------------------------------
	// divides reference output by 1, 2, 4 or 8 to keep band logic slow
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			bcount <= 3'h0;
			band_tick_o <= 1'b0;
		end
		else
		begin
			if (ref_out_o)
				bcount <= band_hit ? 3'h0 : bcount + 3'h1;
			band_tick_o <= band_hit;
		end
	end

	// ----------------------------------------------------------------
	// digital lock detect and monitor pin
	// ----------------------------------------------------------------
	// a missed or lone edge restarts the run of good cycles
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			lock_run <= 3'h0;
			locked_o <= 1'b0;
			monitor_output_pin_o <= 1'b0;
		end
		else
		begin
			lock_run <= next_lock_run;
			locked_o <= next_lock_run >= lock_need;
			monitor_output_pin_o <= monitor_value;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	a_shift_on_edge:
	assert property (sclk_rise |=> shift[0] == $past(sdata_i) && shift[23:1] == $past(shift[22:0]))
		else $error("shift register missed a serial bit");

	a_route_feedback:
	assert property (load_rise && word_sel == 2'h2 |=> feedback_q_o == $past(shift))
		else $error("feedback word not latched");

	a_route_reference:
	assert property (load_rise && word_sel == 2'h1 |=> reference_q_o == $past(shift) && $stable(feedback_q_o))
		else $error("reference word not latched");

	a_route_function:
	assert property (load_rise && word_sel == 2'h0 |=> function_q_o == $past(shift) && $stable(reference_q_o))
		else $error("function word not latched");

	a_latch_hold:
	assert property (!load_rise |=> $stable(function_q_o) && $stable(feedback_q_o) && $stable(reference_q_o))
		else $error("latch changed without strobe rise");

	a_counters_held:
	assert property (function_q_o.counter_reset |=> ##1 !ref_out_o && !fb_out_o)
		else $error("counter output while held in reset");

	a_gain_latest:
	assert property (load_fb ##1 (!load_rise) [*2] |-> cp_gain_o == $past(shift[`SSLD_POS_FB_CP_GAIN], 2))
		else $error("gain bit lost latest write");

	a_lock_count:
	assert property ($rose(locked_o) |-> lock_run == (reference_q_o.lock_precision_select ? 3'h5 : 3'h3))
		else $error("lock entered after wrong cycle count");

	a_monitor_lock:
	assert property (function_q_o.monitor_select == 3'h1 && $stable(function_q_o) |=> monitor_output_pin_o == $past(locked_o))
		else $error("monitor pin not showing lock");

	a_halved_input:
	assert property (feedback_q_o.div2_select && !held && fb_tick |=> !fb_tick || !feedback_q_o.div2_select)
		else $error("halved prescaler input passed a tick");

endmodule

// ---- tb/serial_host.sv ----
// host model driving the three-wire serial port of the latch decoder
`timescale 1ns/1ns
`include "synth_serial_latch_decoder_consts.svh"
module serial_host #(
	parameter logic [1:0] CORE_CODE = 2'h1
) (
	// clock the host paces itself on
	input wire logic clock_i,
	// serial port towards the device
	output logic sclk_o,
	output logic sdata_o,
	output logic load_strobe_o
);
	// ----------------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------------
	initial
	begin
		sclk_o = 1'h0;
		sdata_o = 1'h0;
		load_strobe_o = 1'h0;
	end

	// ----------------------------------------------------------------
	// one word, optionally committed with a strobe pulse
	// ----------------------------------------------------------------
	// fields the host must keep are forced here, so callers cannot slip
	task automatic send(input logic [23:0] word, input logic commit);
		logic [23:0] w;
		w = word;
		if (w[1:0] == `SSLD_SEL_FUNCTION)
			w[3:2] = CORE_CODE; // recommended core current
		if (w[1:0] == `SSLD_SEL_FEEDBACK)
			w[7] = 1'h0; // reserved bit low
		if (w[1:0] == `SSLD_SEL_REFERENCE)
			w[23:19] = {2'h0, w[21:20], 1'h0}; // reserved and test bits low
		for (int i = 23; i >= 0; i--) // msb first, select pair last
		begin
			@(negedge clock_i);
			sclk_o = 1'h0;
			sdata_o = w[i];
			@(negedge clock_i);
			sclk_o = 1'h1; // 10 MHz serial clock, below the 20 MHz ceiling
		end
		@(negedge clock_i);
		sclk_o = 1'h0;
		sdata_o = ~w[0]; // released line shows a changed level, not the last bit
		if (commit)
		begin
			load_strobe_o = 1'h1; // rising strobe commits the word
			@(negedge clock_i);
			load_strobe_o = 1'h0;
		end
	endtask
endmodule

// ---- tb/synth_serial_latch_decoder_tb.sv ----
// self-checking bench for the serial latch decoder
`timescale 1ns/1ns
`include "synth_serial_latch_decoder_consts.svh"
module synth_serial_latch_decoder_tb;
	localparam logic [1:0] CORE = 2'h2;
	logic clock_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic sclk, sdata, strobe;
	logic ref_tick = 1'h0;
	logic vco_tick = 1'h0;
	synth_serial_latch_decoder_pkg::function_latch_t fq;
	synth_serial_latch_decoder_pkg::feedback_latch_t bq;
	synth_serial_latch_decoder_pkg::reference_latch_t rq;
	logic cp_gain, held, ref_out, fb_out, band_tick, locked, mon;
	int fail_count = 0;
	int comparisons = 0;
	int n_ref, n_fb, n_band;
	logic [23:0] rw, bw, fwd;
	logic [2:0] mons [3] = '{3'h0, 3'h3, 3'h7};

	// ----------------------------------------------------------------
	// clock, instances
	// ----------------------------------------------------------------
	always #25 clock_i = ~clock_i;

	serial_host #(.CORE_CODE(CORE)) host (.clock_i(clock_i), .sclk_o(sclk), .sdata_o(sdata), .load_strobe_o(strobe));

	// small prescaler keeps feedback counts short
	synth_serial_latch_decoder #(.PRESCALER_P(4)) uut (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sdata_i(sdata), .load_strobe_i(strobe),
		.ref_tick_i(ref_tick), .vco_tick_i(vco_tick), .function_q_o(fq), .feedback_q_o(bq), .reference_q_o(rq),
		.cp_gain_o(cp_gain), .counters_held_o(held), .ref_out_o(ref_out), .fb_out_o(fb_out),
		.band_tick_o(band_tick), .locked_o(locked), .monitor_output_pin_o(mon));

	// pulse counters, sampled where the pulses are settled
	always @(posedge clock_i)
	begin
		if (ref_out === 1'h1) n_ref++;
		if (fb_out === 1'h1) n_fb++;
		if (band_tick === 1'h1) n_band++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask

	// latch shows one cycle after the commit edge; one more for echoes
	task automatic wr(input logic [23:0] w);
		host.send(w, 1'h1);
		repeat (2) @(negedge clock_i);
	endtask

	function automatic logic [23:0] fw(input logic g, input logic [2:0] m, input logic r);
		return {12'h000, 1'h0, g, 2'h0, m, r, CORE, `SSLD_SEL_FUNCTION};
	endfunction

	// ticks both counter inputs, then compares pulse totals
	task automatic ticks(input int nr, input int nv, input int er, input int ef, input int eb);
		n_ref = 0;
		n_fb = 0;
		n_band = 0;
		for (int i = 0; i < (nr > nv ? nr : nv) + 4; i++)
		begin
			@(negedge clock_i);
			ref_tick = (i < nr);
			vco_tick = (i < nv);
		end
		chk(n_ref[23:0], er[23:0]);
		chk(n_fb[23:0], ef[23:0]);
		chk(n_band[23:0], eb[23:0]);
	endtask

	task automatic tally_and_finish;
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog: tests need well under 5000 cycles
	// ----------------------------------------------------------------
	initial
	begin
		#1000000;
		fail_count++;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(negedge clock_i);
		sys_rst_i = 1'h0;
		@(negedge clock_i);
		chk(fq | bq | rq, 24'h000000);
		chk({cp_gain, held, ref_out, fb_out, band_tick, locked, mon}, 24'h000000);
		// reference first: ratio 3, backlash code 2, five-cycle lock, band divide by 2
		rw = {2'h0, 2'h1, 1'h0, 1'h1, 2'h2, 14'h0003, `SSLD_SEL_REFERENCE};
		wr(rw);
		chk(rq, rw);
		chk(fq | bq, 24'h000000);
		wr(fw(1'h1, 3'h3, 1'h0));
		chk(fq, fw(1'h1, 3'h3, 1'h0));
		chk(cp_gain, 24'h000001);
		// constant monitor sources: low, high, low
		for (int i = 0; i < 3; i++)
		begin
			wr(fw(1'h1, mons[i], 1'h0));
			chk(mon, mons[i] == 3'h3);
		end
		// boundary counts, divide-by-2 both on, gain written low
		bw = {1'h1, 1'h1, 1'h0, 13'h0003, 1'h0, 5'h1F, `SSLD_SEL_FEEDBACK};
		wr(bw);
		chk(bq, bw);
		chk(cp_gain, 24'h000000);
		// test latch select and unstrobed shifting leave all latches alone
		fwd = fw(1'h1, 3'h7, 1'h0);
		wr(24'hFFFFFF);
		host.send(24'hABCD6A, 1'h0);
		repeat (3) @(negedge clock_i);
		chk(rq, rw);
		chk(bq, bw);
		chk(fq, fwd);
		// ratio 3 reference, band every 2nd, feedback 4*3+31 on halved ticks
		ticks(12, 86, 4, 1, 2);
		bw = {3'h0, 13'h0003, 1'h0, 5'h02, `SSLD_SEL_FEEDBACK};
		wr(bw);
		ticks(0, 28, 0, 2, 0);
		// counters held while the reset bit is set
		wr(fw(1'h0, 3'h1, 1'h1));
		chk(held, 24'h000001);
		ticks(12, 28, 0, 0, 0);
		// matched ratios of 12 give coincident pulses from a common start
		wr({2'h0, 2'h0, 1'h0, 1'h1, 2'h0, 14'h000C, `SSLD_SEL_REFERENCE});
		wr({3'h0, 13'h0003, 1'h0, 5'h00, `SSLD_SEL_FEEDBACK});
		wr(fw(1'h0, 3'h1, 1'h0));
		chk(held, 24'h000000);
		ticks(54, 54, 4, 4, 4);
		chk(locked, 24'h000000);
		ticks(12, 12, 1, 1, 1);
		chk(locked, 24'h000001);
		chk(mon, 24'h000001);
		// lone reference pulse breaks lock; three-cycle precision relocks
		ticks(12, 0, 1, 0, 1);
		chk(locked, 24'h000000);
		wr({2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 14'h000C, `SSLD_SEL_REFERENCE});
		ticks(24, 24, 2, 2, 2);
		chk(locked, 24'h000000);
		ticks(12, 12, 1, 1, 1);
		chk(locked, 24'h000001);
		// data source: the released line shows the inverse of the last select bit
		wr(fw(1'h0, 3'h6, 1'h0));
		chk(mon, 24'h000001);
		tally_and_finish;
	end
endmodule
